// file: rtl/rxcfg_pkg.sv
// package of register map, field layouts and timing for the receiver config bank
package rxcfg_pkg;
    localparam logic [7:0] ADDR_SST    = 8'h06;
    localparam logic [7:0] ADDR_RXC1   = 8'h0B;
    localparam logic [7:0] ADDR_RXC2   = 8'h0C;
    localparam logic [7:0] ADDR_RXC3   = 8'h0D;
    localparam logic [7:0] ADDR_IRQST  = 8'h20;
    localparam logic [7:0] ADDR_IRQMSK = 8'h21;
    localparam logic [7:0] ADDR_CTRL   = 8'h22;
    localparam logic [7:0] ADDR_SQT    = 8'h23;
    localparam logic [7:0] RST_SST     = 8'h00;
    localparam logic [7:0] RST_RXC1    = 8'h00;
    localparam logic [7:0] RST_RXC2    = 8'h2C;
    localparam logic [7:0] RST_RXC3    = 8'hD8;
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam int SST_W      = 5;
    localparam int B_CHSEL    = 7;
    localparam int B_DEMOD    = 7;
    localparam int B_AMDSEL   = 6;
    localparam int B_SQDYN    = 5;
    localparam int B_SQRATIO  = 4;
    localparam int B_AGCEN    = 3;
    localparam int B_AGCWIN   = 2;
    localparam int B_AGCALG   = 1;
    localparam int B_AGCRAT   = 0;
    localparam int B_LFSEL    = 1;
    localparam int B_LFSPLIT  = 0;
    localparam int B_EMDEN    = 0;
    localparam int B_TYPEB106 = 1;
    localparam int IRQ_SOFT   = 0;
    localparam int IRQ_RESTART = 1;
    localparam int IRQ_BADIQ  = 2;
    // squelch start delay after end of transmit
    localparam int SQ_DELAY_PS  = 18880000;
    localparam int CLK_PERIOD_PS = 20000;
    localparam int SQ_DELAY_CYC = (SQ_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int AGC_WIN_PULSES = 8;
    typedef struct packed {
        logic       channel_pm;
        logic       demod_iq;
        logic       squelch_on;
        logic       squelch_ratio_hi;
        logic       agc_on;
        logic       agc_window_full;
        logic       agc_reset_alg;
        logic       gain_control_ratio;
        logic [2:0] first_stage_gain_am;
        logic [2:0] first_stage_gain_pm;
        logic       low_freq_input_select;
        logic       low_freq_split_routing;
    } rxcfg_rx_s;
endpackage : rxcfg_pkg

// file: rtl/rxcfg_bank.sv
// receiver configuration register bank with subcarrier timing and squelch control
// Function
// - start time is five bits, quarter etu steps
// - early subcarrier at B106 raises soft error
// - with EMD enabled, discard frame, raise restart
// - channel bit picks AM or PM
// - I/Q demod valid only with mixer
// - squelch from 18.88us after TX until timer
// - squelch ratio bit: 1 or 6/3
// - AGC enable and window bits
// - AGC ratio bit: 3 or 6
// - three bit first stage gain codes
// - LF input select and split routing
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module rxcfg_bank
    import rxcfg_pkg::*;
#(
    parameter int QETU_CYC = 24  // clock cycles per quarter etu
) (
    input  wire logic       clk,          // 50 MHz clock
    input  wire logic       rst_b,        // async reset, active low
    input  wire logic [7:0] addr,         // register address
    input  wire logic [7:0] wdata,        // write data
    input  wire logic       wr,           // write strobe
    input  wire logic       rd,           // read strobe
    output logic      [7:0] rdata,        // read data, cycle after rd
    output logic            irq,          // level interrupt
    input  wire logic       tx_end,       // pulse: transmission ended
    input  wire logic       mrt_expired,  // pulse: mask receive timer ended
    input  wire logic [7:0] mrt_value,    // mask receive timer count
    input  wire logic       subc_det_pin, // subcarrier detected, async level
    input  wire logic       rx_end,       // pulse: reception over
    output logic            frame_discard, // pulse: frame dropped as EMD
    output logic            squelch_act,  // squelch active
    output logic            agc_active,   // agc running
    output rxcfg_rx_s       rx_cfg        // settings to the receive path
);
    if (QETU_CYC < 1 || QETU_CYC > 4095) begin : g_qetu_check
        $error("QETU_CYC out of range");  // 12-bit cycle counter limits the step length
    end

    typedef enum logic [1:0] {
        RXCFG_IDLE = 2'b00,
        RXCFG_WAIT = 2'b01,
        RXCFG_TIME = 2'b10,
        RXCFG_DONE = 2'b11
    } rxcfg_sc_e;

    // gain code decode: 0 full, 1-6 cut, 7 boost
    function automatic logic gain_is_boost(input logic [2:0] code);
        return code == 3'h7;
    endfunction

    logic [7:0] sst_ff, rxc1_ff, rxc2_ff, rxc3_ff, ctrl_ff, sqt_ff, msk_ff, st_ff;
    logic [7:0] nxt_sst, nxt_rxc1, nxt_rxc2, nxt_rxc3, nxt_ctrl, nxt_sqt, nxt_msk, nxt_st;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       irq_ff, nxt_irq;
    logic [2:0] det_sync_ff;
    logic       det_ff, nxt_det;
    rxcfg_sc_e  sc_ff, nxt_sc;
    logic [6:0] qetu_ff, nxt_qetu;
    logic [11:0] cyc_ff, nxt_cyc;
    logic       disc_ff, nxt_disc;
    logic       soft_ev, restart_ev, badiq_ev;
    logic [9:0] sqd_ff, nxt_sqd;
    logic       sq_ff, nxt_sq;
    logic       sqw_ff, nxt_sqw;
    logic [3:0] pulses_ff, nxt_pulses;
    logic       agc_ff, nxt_agc;
    logic       in_rx_ff, nxt_in_rx;
    rxcfg_rx_s  cfg_ff, nxt_cfg;
    logic       det_rise;

    // pin synchroniser, accepted once stages two and three agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            det_sync_ff <= 3'h0;
        end else begin
            det_sync_ff <= {det_sync_ff[1:0], subc_det_pin};
        end
    end

    always_comb begin
        nxt_det = det_ff;
        if (det_sync_ff[1] == det_sync_ff[2]) begin
            nxt_det = det_sync_ff[2];
        end
    end
    assign det_rise = nxt_det && !det_ff;

    // register writes and read mux; reserved bits of SST, CTRL and IRQMSK forced to zero, RXC1 stores all eight bits
    always_comb begin
        nxt_sst   = sst_ff;
        nxt_rxc1  = rxc1_ff;
        nxt_rxc2  = rxc2_ff;
        nxt_rxc3  = rxc3_ff;
        nxt_ctrl  = ctrl_ff;
        nxt_sqt   = sqt_ff;
        nxt_msk   = msk_ff;
        nxt_rdata = 8'h00;
        if (wr) begin
            unique case (addr)
                ADDR_SST:    nxt_sst = {3'h0, wdata[SST_W-1:0]};
                ADDR_RXC1:   nxt_rxc1 = wdata;
                ADDR_RXC2:   nxt_rxc2 = wdata;
                ADDR_RXC3:   nxt_rxc3 = wdata;
                ADDR_CTRL:   nxt_ctrl = {6'h00, wdata[1:0]};
                ADDR_SQT:    nxt_sqt = wdata;
                ADDR_IRQMSK: nxt_msk = {5'h00, wdata[2:0]};
                default:     nxt_ctrl = ctrl_ff;  // unmapped writes ignored
            endcase
        end
        if (rd) begin
            unique case (addr)
                ADDR_SST:    nxt_rdata = sst_ff;
                ADDR_RXC1:   nxt_rdata = rxc1_ff;
                ADDR_RXC2:   nxt_rdata = rxc2_ff;
                ADDR_RXC3:   nxt_rdata = rxc3_ff;
                ADDR_CTRL:   nxt_rdata = ctrl_ff;
                ADDR_SQT:    nxt_rdata = sqt_ff;
                ADDR_IRQMSK: nxt_rdata = msk_ff;
                ADDR_IRQST:  nxt_rdata = st_ff;
                default:     nxt_rdata = 8'h00;  // unmapped reads as zero
            endcase
        end
    end

    // subcarrier start timing after the mask receive timer ends
    always_comb begin
        nxt_sc     = sc_ff;
        nxt_cyc    = cyc_ff;
        nxt_qetu   = qetu_ff;
        soft_ev    = 1'b0;
        restart_ev = 1'b0;
        nxt_disc   = 1'b0;
        unique case (sc_ff)
            RXCFG_IDLE: begin
                if (mrt_expired && ctrl_ff[B_TYPEB106]) begin
                    nxt_sc   = RXCFG_TIME;
                    nxt_cyc  = 12'h000;
                    nxt_qetu = 7'h00;
                end
            end
            RXCFG_TIME: begin
                if (det_rise) begin
                    nxt_sc = RXCFG_DONE;
                    // too early: elapsed quarter etu below the programmed time
                    if (qetu_ff < {2'h0, sst_ff[SST_W-1:0]}) begin
                        if (ctrl_ff[B_EMDEN]) begin
                            restart_ev = 1'b1;
                            nxt_disc   = 1'b1;
                        end else begin
                            soft_ev = 1'b1;
                        end
                    end
                end else if (cyc_ff == 12'(QETU_CYC - 1)) begin
                    nxt_cyc = 12'h000;
                    // saturate; anything past the field range is late enough
                    if (qetu_ff != 7'h7F) begin
                        nxt_qetu = qetu_ff + 7'h01;
                    end
                end else begin
                    nxt_cyc = cyc_ff + 12'h001;
                end
            end
            RXCFG_DONE: begin
                if (rx_end) begin
                    nxt_sc = RXCFG_IDLE;
                end
            end
            RXCFG_WAIT: nxt_sc = RXCFG_IDLE;
        endcase
        if (tx_end) begin
            nxt_sc = RXCFG_IDLE;
        end
    end

    // squelch: delayed start after TX end, stop when mrt reaches threshold
    always_comb begin
        nxt_sqd = sqd_ff;
        nxt_sq  = sq_ff;
        nxt_sqw = sqw_ff;
        if (tx_end && rxc2_ff[B_SQDYN]) begin
            nxt_sqw = 1'b1;
            nxt_sqd = 10'h000;
            nxt_sq  = 1'b0;
        end else if (sqw_ff) begin
            if (sqd_ff == 10'(SQ_DELAY_CYC - 1)) begin
                nxt_sqw = 1'b0;
                nxt_sq  = 1'b1;
            end else begin
                nxt_sqd = sqd_ff + 10'h001;
            end
        end else if (sq_ff && mrt_value >= sqt_ff) begin
            nxt_sq = 1'b0;
        end
        if (!rxc2_ff[B_SQDYN]) begin
            nxt_sq  = 1'b0;
            nxt_sqw = 1'b0;
        end
    end

    // agc: first eight subcarrier pulses or whole receive period
    always_comb begin
        nxt_pulses = pulses_ff;
        nxt_in_rx  = in_rx_ff;
        if (mrt_expired) begin
            nxt_in_rx  = 1'b1;
            nxt_pulses = 4'h0;
        end else if (rx_end || tx_end) begin
            nxt_in_rx = 1'b0;
        end else if (det_rise && pulses_ff != 4'(AGC_WIN_PULSES)) begin
            nxt_pulses = pulses_ff + 4'h1;
        end
        nxt_agc = rxc2_ff[B_AGCEN] && in_rx_ff
                  && (rxc2_ff[B_AGCWIN] || pulses_ff < 4'(AGC_WIN_PULSES));
    end

    // configuration view for the receive path
    always_comb begin
        nxt_cfg.channel_pm             = rxc1_ff[B_CHSEL];
        // i/q demod only honoured when the mixer is the am demodulator
        nxt_cfg.demod_iq               = rxc2_ff[B_DEMOD] & rxc2_ff[B_AMDSEL];
        nxt_cfg.squelch_on             = rxc2_ff[B_SQDYN];
        nxt_cfg.squelch_ratio_hi       = rxc2_ff[B_SQRATIO];
        nxt_cfg.agc_on                 = rxc2_ff[B_AGCEN];
        nxt_cfg.agc_window_full        = rxc2_ff[B_AGCWIN];
        nxt_cfg.agc_reset_alg          = rxc2_ff[B_AGCALG];
        nxt_cfg.gain_control_ratio     = rxc2_ff[B_AGCRAT];
        nxt_cfg.first_stage_gain_am    = rxc3_ff[7:5];
        nxt_cfg.first_stage_gain_pm    = rxc3_ff[4:2];
        nxt_cfg.low_freq_input_select  = rxc3_ff[B_LFSEL];
        nxt_cfg.low_freq_split_routing = rxc3_ff[B_LFSPLIT];
        badiq_ev = wr && addr == ADDR_RXC2 && wdata[B_DEMOD] && !wdata[B_AMDSEL];
    end

    // sticky status: set wins over read clear
    always_comb begin
        nxt_st = st_ff;
        if (rd && addr == ADDR_IRQST) begin
            nxt_st = 8'h00;
        end
        nxt_st[IRQ_SOFT]    = nxt_st[IRQ_SOFT] | soft_ev;
        nxt_st[IRQ_RESTART] = nxt_st[IRQ_RESTART] | restart_ev;
        nxt_st[IRQ_BADIQ]   = nxt_st[IRQ_BADIQ] | badiq_ev;
        nxt_irq = |(nxt_st & msk_ff);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sst_ff    <= RST_SST;
            rxc1_ff   <= RST_RXC1;
            rxc2_ff   <= RST_RXC2;
            rxc3_ff   <= RST_RXC3;
            ctrl_ff   <= RST_ZERO;
            sqt_ff    <= RST_ZERO;
            msk_ff    <= RST_ZERO;
            st_ff     <= RST_ZERO;
            rdata_ff  <= RST_ZERO;
            irq_ff    <= 1'b0;
            det_ff    <= 1'b0;
            sc_ff     <= RXCFG_IDLE;
            cyc_ff    <= 12'h000;
            qetu_ff   <= 7'h00;
            disc_ff   <= 1'b0;
            sqd_ff    <= 10'h000;
            sq_ff     <= 1'b0;
            sqw_ff    <= 1'b0;
            pulses_ff <= 4'h0;
            agc_ff    <= 1'b0;
            in_rx_ff  <= 1'b0;
            cfg_ff    <= '0;
        end else begin
            sst_ff    <= nxt_sst;
            rxc1_ff   <= nxt_rxc1;
            rxc2_ff   <= nxt_rxc2;
            rxc3_ff   <= nxt_rxc3;
            ctrl_ff   <= nxt_ctrl;
            sqt_ff    <= nxt_sqt;
            msk_ff    <= nxt_msk;
            st_ff     <= nxt_st;
            rdata_ff  <= nxt_rdata;
            irq_ff    <= nxt_irq;
            det_ff    <= nxt_det;
            sc_ff     <= nxt_sc;
            cyc_ff    <= nxt_cyc;
            qetu_ff   <= nxt_qetu;
            disc_ff   <= nxt_disc;
            sqd_ff    <= nxt_sqd;
            sq_ff     <= nxt_sq;
            sqw_ff    <= nxt_sqw;
            pulses_ff <= nxt_pulses;
            agc_ff    <= nxt_agc;
            in_rx_ff  <= nxt_in_rx;
            cfg_ff    <= nxt_cfg;
        end
    end

    assign rdata         = rdata_ff;
    assign irq           = irq_ff;
    assign frame_discard = disc_ff;
    assign squelch_act   = sq_ff;
    assign agc_active    = agc_ff;
    assign rx_cfg        = cfg_ff;

    a_sst_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
        sst_ff[7:5] == 3'h0) else $error("reserved start timer bits set");
    a_soft_err_flag: assert property (@(posedge clk) disable iff (!rst_b)
        soft_ev |=> st_ff[IRQ_SOFT]) else $error("soft error not flagged");
    a_emd_discard: assert property (@(posedge clk) disable iff (!rst_b)
        restart_ev |=> disc_ff && st_ff[IRQ_RESTART] && !$past(soft_ev))
        else $error("emd discard missing");
    a_early_cause: assert property (@(posedge clk) disable iff (!rst_b)
        (soft_ev || restart_ev) |-> qetu_ff < {2'h0, sst_ff[4:0]} && sc_ff == RXCFG_TIME)
        else $error("early event without cause");
    a_squelch_delay: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(sq_ff) |-> $past(sqw_ff) && $past(sqd_ff) == 10'(SQ_DELAY_CYC - 1))
        else $error("squelch started at wrong time");
    a_squelch_stop: assert property (@(posedge clk) disable iff (!rst_b)
        (sq_ff && !sqw_ff && !tx_end && mrt_value >= sqt_ff) |=> !sq_ff)
        else $error("squelch did not stop");
    a_iq_needs_mixer: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_ff.demod_iq |-> $past(rxc2_ff[B_AMDSEL])) else $error("iq without mixer");
    a_agc_window: assert property (@(posedge clk) disable iff (!rst_b)
        agc_ff && !$past(rxc2_ff[B_AGCWIN]) |-> $past(pulses_ff) < 4'h8)
        else $error("agc past eight pulses");
    a_cfg_follow: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) |-> cfg_ff.gain_control_ratio == $past(rxc2_ff[0])
        && cfg_ff.channel_pm == $past(rxc1_ff[7])
        && cfg_ff.first_stage_gain_am == $past(rxc3_ff[7:5])
        && cfg_ff.low_freq_split_routing == $past(rxc3_ff[0]))
        else $error("config view stale");
    a_boost_code: assert property (@(posedge clk) disable iff (!rst_b)
        gain_is_boost(cfg_ff.first_stage_gain_pm) |-> $past(rxc3_ff[4:2]) == 3'h7)
        else $error("gain code mismatch");
endmodule : rxcfg_bank
`default_nettype wire

// file: sim/rxcfg_card_model.sv
// far-side card model: answers a frame with subcarrier after a set delay
`timescale 1ns/1ps
`default_nettype none
module rxcfg_card_model (
    input  wire logic        clk,      // system clock
    input  wire logic        go,       // frame window open
    input  wire logic [15:0] dly,      // cycles until subcarrier appears
    output logic             subc_det  // subcarrier present
);
    logic [15:0] cnt;
    // a prompt card uses a short delay, a slow one a long delay; no carrier outside a frame
    // subcarrier comes as pulses, four cycles high and four low, so agc can count them
    always @(posedge clk) begin
        if (!go) begin
            cnt      <= 16'h0000;
            subc_det <= 1'b0;
        end else begin
            cnt      <= cnt + 16'h0001;
            subc_det <= (cnt >= dly) && (((cnt - dly) & 16'h0004) == 16'h0000);
        end
    end
endmodule // rxcfg_card_model
`default_nettype wire

// file: sim/rxcfg_bank_test.sv
// self-checking bench for the receiver configuration bank
`timescale 1ns/1ps
`default_nettype none
module rxcfg_bank_test;
    import rxcfg_pkg::*;
    localparam int QC = 4; // short quarter etu keeps the run brief
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [2:0]  ev = 3'h0;     // tx end, timer end, rx end pulses
    logic [7:0]  mrt_value = 8'h00;
    logic        card_go = 1'b0;
    logic [15:0] card_dly = 16'h0000;
    logic [7:0]  rdata, c1, c2, c3, s, d;
    logic        irq, frame_discard, squelch_act, agc_active, subc_det, bad;
    rxcfg_rx_s   rx_cfg;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          seed = 81;
    int          fd_cnt = 0;
    int          n;

    rxcfg_bank #(.QETU_CYC(QC)) u_rxcfg_bank (
        .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq), .tx_end(ev[0]), .mrt_expired(ev[1]),
        .mrt_value(mrt_value), .subc_det_pin(subc_det), .rx_end(ev[2]),
        .frame_discard(frame_discard), .squelch_act(squelch_act),
        .agc_active(agc_active), .rx_cfg(rx_cfg));
    rxcfg_card_model u_rxcfg_card_model (
        .clk(clk), .go(card_go), .dly(card_dly), .subc_det(subc_det));

    always #10 clk = ~clk;
    // discard is a one-cycle pulse, so count every cycle it shows
    always @(posedge clk) if (frame_discard === 1'b1) fd_cnt++;

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a; wdata <= v; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk_val({8'h00, rdata}, {8'h00, exp});
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    function automatic rxcfg_rx_s exp_cfg(input logic [7:0] r1, r2, r3);
        exp_cfg = '{r1[B_CHSEL], r2[B_DEMOD] & r2[B_AMDSEL], r2[B_SQDYN], r2[B_SQRATIO],
                    r2[B_AGCEN], r2[B_AGCWIN], r2[B_AGCALG], r2[B_AGCRAT], r3[7:5], r3[4:2],
                    r3[B_LFSEL], r3[B_LFSPLIT]};
    endfunction
    // one frame: timer end, card answers after dly, then reception ends
    task automatic sc_run(input logic [7:0] ctl, msk, input logic [15:0] dly,
                          input logic [7:0] st, input int fd);
        wr_reg(ADDR_CTRL, ctl);
        wr_reg(ADDR_IRQMSK, msk);
        card_dly <= dly;
        fd_cnt = 0;
        pulse(1);
        card_go <= 1'b1;
        cyc(3);
        chk_bit(agc_active, 1'b1);
        cyc(int'(dly) + 12);
        chk_bit(irq, (st & msk) != 8'h00);
        pulse(2);
        card_go <= 1'b0;
        cyc(3);
        chk_bit(agc_active, 1'b0);
        rd_chk(ADDR_IRQST, st);
        chk_val(16'(fd_cnt), 16'(fd));
        cyc(2);
        chk_bit(irq, 1'b0);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        cyc(2);
        chk_val(rx_cfg, exp_cfg(RST_RXC1, RST_RXC2, RST_RXC3));
        rd_chk(ADDR_SST, RST_SST);
        rd_chk(ADDR_RXC1, RST_RXC1);
        rd_chk(ADDR_RXC2, RST_RXC2);
        rd_chk(ADDR_RXC3, RST_RXC3);
        rd_chk(8'h30, 8'h00);
        bad = 1'b0;
        // random settings, with a bad and a good I/Q choice forced first
        for (int i = 0; i < 8; i++) begin
            c1 = 8'($random(seed));
            c2 = (i == 0) ? 8'h80 : (i == 1) ? 8'hC0 : 8'($random(seed));
            c3 = 8'($random(seed));
            s = 8'($random(seed)) & 8'h1F;
            bad = bad | (c2[B_DEMOD] & ~c2[B_AMDSEL]);
            wr_reg(ADDR_SST, s);
            wr_reg(ADDR_RXC1, c1);
            wr_reg(ADDR_RXC2, c2);
            wr_reg(ADDR_RXC3, c3);
            rd_chk(ADDR_SST, s);
            rd_chk(ADDR_RXC1, c1);
            rd_chk(ADDR_RXC2, c2);
            rd_chk(ADDR_RXC3, c3);
            chk_val(rx_cfg, exp_cfg(c1, c2, c3));
        end
        chk_bit(irq, 1'b0);
        wr_reg(ADDR_IRQMSK, 8'h04);
        cyc(2);
        chk_bit(irq, bad);
        rd_chk(ADDR_IRQST, {5'h00, bad, 2'h0});
        wr_reg(ADDR_RXC2, RST_RXC2);
        wr_reg(ADDR_SST, 8'h08);
        sc_run(8'h02, 8'h07, 16'd8, 8'h01, 0);
        sc_run(8'h03, 8'h07, 16'd8, 8'h02, 1);
        sc_run(8'h02, 8'h07, 16'd60, 8'h00, 0);
        sc_run(8'h00, 8'h07, 16'd8, 8'h00, 0);
        sc_run(8'h02, 8'h00, 16'd8, 8'h01, 0);
        wr_reg(ADDR_SST, 8'h00);
        sc_run(8'h02, 8'h07, 16'd8, 8'h00, 0);
        // window limited to eight pulses: gain control stops while the frame still runs
        wr_reg(ADDR_RXC2, 8'h28);
        card_dly <= 16'd8;
        pulse(1);
        card_go <= 1'b1;
        cyc(40);
        chk_bit(agc_active, 1'b1);
        cyc(60);
        chk_bit(agc_active, 1'b0);
        pulse(2);
        card_go <= 1'b0;
        cyc(3);
        // squelch starts a fixed delay after transmit ends, stops at the timer setting
        wr_reg(ADDR_SQT, 8'h05);
        pulse(0);
        cyc(SQ_DELAY_CYC - 10);
        chk_bit(squelch_act, 1'b0);
        n = 0;
        while (squelch_act !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk_val(16'(n), 16'd10);
        @(posedge clk);
        mrt_value <= 8'h05;
        cyc(3);
        chk_bit(squelch_act, 1'b0);
        @(posedge clk);
        mrt_value <= 8'h00;
        wr_reg(ADDR_RXC2, 8'h0C);
        pulse(0);
        cyc(SQ_DELAY_CYC + 20);
        chk_bit(squelch_act, 1'b0);
        close_out();
    end
endmodule // rxcfg_bank_test
`default_nettype wire
